// File: bench/bst_link_assertions.sv
// Purpose: Link checks between the scan controller and the TAP
// Assumes: Both ends run on sys_clk; link pins are plain levels
// Notes: tck half length is counted, so it follows TCK_HALF
`timescale 1ns/10ps
`default_nettype none
module bst_link_assertions #(
   parameter int TCK_HALF = 8
) (
   // System
   input wire logic sys_clk,
   input wire logic rst,
   // Link
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   input wire logic tdo
);
   localparam int HMAX = 300;
   logic tck_q, seen_reg;
   int run_reg;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   // Cycles since last tck edge; first edge skipped, its start is arbitrary
   always_ff @(posedge sys_clk) begin
      tck_q <= tck;
      seen_reg <= rst ? 1'b0 : (seen_reg | (tck != tck_q));
      run_reg <= (rst || tck != tck_q) ? 0 : run_reg + 1;
   end
   ////////////////////////////////////////////////////////////////
   a_tdo_on_low: assert property (trst_n && tck |-> $stable(tdo))
      else $error("tdo moved while tck high");
   a_tms_on_low: assert property ($changed(tms) |-> !tck)
      else $error("tms moved while tck high");
   a_tdi_on_low: assert property ($changed(tdi) |-> !tck)
      else $error("tdi moved while tck high");
   a_rise_hold: assert property ($rose(tck) |=> $stable({tms, tdi})[*3])
      else $error("tms or tdi not held after tck rise");
   a_tck_half_len: assert property (seen_reg && tck != tck_q |-> run_reg == TCK_HALF - 1)
      else $error("tck half period wrong");
   a_tck_runs: assert property ($rose(tck) |-> ##[1:HMAX] $fell(tck))
      else $error("tck stuck high");
   a_trst_quiets_tdo: assert property (!trst_n [*4] |-> !tdo)
      else $error("tdo not quiet under trst");
   a_trst_after_reset: assert property ($fell(rst) |-> !trst_n)
      else $error("trst_n not held low after reset");
   // Main scenarios seen
   c_trst_release: cover property ($rose(trst_n));
   c_tdo_high: cover property ($rose(tdo));
   c_tck_edge: cover property (seen_reg && tck != tck_q);
endmodule
`default_nettype wire

// File: bench/test_boundary_scan_tap.sv
// Purpose: Drives the scan controller over APB and checks the TAP cell ports
// Assumes: Controller and TAP share sys_clk; tck comes from the controller
// Notes: TCK_HALF cut to 6 to keep shifts short
`timescale 1ns/10ps
`default_nettype none
module test_boundary_scan_tap
   import bst_pkg::*;
;
   localparam int TH = 6;
   localparam logic [24:0] PIN = 25'h1a5c3e9;
   localparam logic [24:0] CORE = 25'h0b3d6a5;
   localparam logic [31:0] TXB = 32'h2c9e1b7;
   logic sys_clk, pready, tap_reset;
   logic rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic [24:0] pin_in = PIN, core_out = CORE, pin_out, core_in;
   logic [3:0] instr, chain;
   int failures = 0, samples_checked = 0;
   bst_tap_if link ();
   bst_tap_dev u_bst_tap_dev (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .link(link.dev),
      .core_out(core_out), .pin_in(pin_in), .pin_out(pin_out), .core_in(core_in),
      .instr(instr), .chain(chain), .tap_reset(tap_reset));
   bst_tap_host #(.TCK_HALF(TH)) u_bst_tap_host (.sys_clk(sys_clk), .rst(rst), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(), .link(link.host));
   bst_link_assertions #(.TCK_HALF(TH)) u_bst_link_assertions (.sys_clk(sys_clk), .rst(rst),
      .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .trst_n(link.trst_n), .tdo(link.tdo));
   ////////////////////////////////////////////////////////////////
   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
                      output logic [31:0] r);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge sys_clk) penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Poll busy until it clears; only the watchdog ends a hang
   task automatic wait_idle(output logic [31:0] rx);
      do apb(1'b0, BST_OFF_STAT, 32'h0, rx);
      while (rx[BST_STAT_BUSY] !== 1'b0);
   endtask
   // TX first, then GO, then wait for the sequencer to go idle
   task automatic shift(input logic ir, input int n, input logic [31:0] tx,
                        output logic [31:0] rx);
      apb(1'b1, BST_OFF_TX, tx, rx);
      apb(1'b1, BST_OFF_CTRL, {19'h0, 5'(n - 1), 6'h0, ir, 1'b1}, rx);
      wait_idle(rx);
      apb(1'b0, BST_OFF_RX, 32'h0, rx);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask
   task automatic give_verdict;
      $display("Checked %0d, failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset_state;
      chk(instr, BST_OP_IDCODE, "reset instr");
      chk(chain, BST_CHAIN_BOUNDARY, "reset chain");
      chk(tap_reset, 1'b1, "reset state");
      apb(1'b1, BST_OFF_CTRL, 32'h0, d);
   endtask
   task automatic t_bypass;
      shift(1'b1, 4, 32'hf, d);
      chk(d[3:0], BST_IR_CAPTURE, "ir capture");
      chk(instr, BST_OP_BYPASS, "ir update");
      chk(tap_reset, 1'b0, "left reset");
      shift(1'b0, 2, 32'h1, d);
      chk(d[1:0], 2'b10, "bypass path");
      chk(pin_out, CORE, "pins normal");
      chk(core_in, PIN, "core normal");
      shift(1'b1, 4, 32'h5, d);
      apb(1'b0, BST_OFF_STAT, 32'h0, d);
      chk(d[BST_STAT_ERR], 1'b1, "reserved code taken");
      chk(instr, BST_OP_BYPASS, "instr kept");
      apb(1'b1, BST_OFF_STAT, 32'h2, d);
      apb(1'b0, BST_OFF_STAT, 32'h0, d);
      chk(d[BST_STAT_ERR], 1'b0, "err cleared");
   endtask
   task automatic t_select;
      shift(1'b1, 4, 32'h2, d);
      shift(1'b0, 4, 32'h3, d);
      chk(d[3:0], BST_SEL_CAPTURE, "select capture");
      chk(chain, BST_CHAIN_BOUNDARY, "select update");
      shift(1'b0, 4, 32'h5, d);
      apb(1'b0, BST_OFF_STAT, 32'h0, d);
      chk(d[BST_STAT_ERR], 1'b1, "reserved chain taken");
      chk(chain, BST_CHAIN_BOUNDARY, "chain kept");
      apb(1'b1, BST_OFF_STAT, 32'h2, d);
   endtask
   // Shared boundary pass: capture, 25 clock latency, cell drive
   task automatic t_bound(input logic [3:0] op, input logic [24:0] cap, input logic [24:0] m);
      logic [24:0] got, ch;
      shift(1'b1, 4, {28'h0, op}, d);
      chk(instr, op, "mode instr");
      shift(1'b0, 26, TXB, d);
      for (int i = 0; i < 25; i++) begin
         got[24 - i] = d[i];
         ch[i] = TXB[25 - i];
      end
      chk(got & m, cap & m, "capture");
      chk(d[25], TXB[0], "latency");
      chk(pin_out, (op == BST_OP_EXTEST) ? (ch & BST_CELL_OUT) | (CORE & ~BST_CELL_OUT)
         : CORE, "pin drive");
      chk(core_in, (op == BST_OP_INTEST) ? (ch & BST_CELL_IN) | (PIN & ~BST_CELL_IN)
         : PIN, "core drive");
   endtask
   // Five tms ones walk the TAP to reset; decode, chain and cells fall back
   task automatic t_tlr;
      apb(1'b1, BST_OFF_CTRL, 32'h5, d);
      wait_idle(d);
      chk(instr, BST_OP_IDCODE, "tlr instr");
      chk(chain, BST_CHAIN_BOUNDARY, "tlr chain");
      chk(pin_out, CORE, "pins released");
      chk(core_in, PIN, "core released");
   endtask
   task automatic t_trst;
      apb(1'b1, BST_OFF_CTRL, 32'h8, d);
      repeat (6) @(posedge sys_clk);
      chk(tap_reset, 1'b1, "trst reset");
      chk(instr, BST_OP_IDCODE, "trst instr");
      apb(1'b1, BST_OFF_CTRL, 32'h0, d);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Watchdog, about eight times the expected run
   initial begin
      #200000;
      failures++;
      $display("Error at %0t: timeout", $time);
      give_verdict;
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset_state;
      t_bypass;
      t_select;
      t_bound(BST_OP_SAMPLE, (PIN & BST_CELL_IN) | (CORE & ~BST_CELL_IN), '1);
      t_bound(BST_OP_INTEST, (CORE & BST_CELL_OUT) | (PIN & ~BST_CELL_OUT), '1);
      t_bound(BST_OP_EXTEST, PIN, BST_CELL_IN);
      t_tlr;
      t_trst;
      give_verdict;
   end
endmodule
`default_nettype wire

// File: hw/bst_pkg.sv
// Purpose: Shared constants and types for the boundary-scan TAP and its controller
// Assumes: Both ends run on sys_clk; link pins are sampled, never used as clocks
// Notes: Boundary cell order runs from chain_first_pin (bit 0) to chain_last_pin (bit 24)
package bst_pkg;
   // Instruction register
   localparam int BST_IR_W = 4;
   localparam logic [3:0] BST_IR_CAPTURE = 4'h1;
   localparam logic [3:0] BST_OP_EXTEST = 4'h0;
   localparam logic [3:0] BST_OP_SELECT = 4'h2;
   localparam logic [3:0] BST_OP_SAMPLE = 4'h3;
   localparam logic [3:0] BST_OP_INTEST = 4'hc;
   localparam logic [3:0] BST_OP_BYPASS = 4'hf;
   localparam logic [3:0] BST_OP_IDCODE = 4'he; // Reserved code, value arbitrary
   // Scan path select register
   localparam int BST_SEL_W = 4;
   localparam logic [3:0] BST_SEL_CAPTURE = 4'h8;
   localparam logic [3:0] BST_CHAIN_BOUNDARY = 4'h3;
   // Boundary chain, bit 0 is chain_first_pin
   localparam int BST_BSR_LEN = 25;
   localparam logic [24:0] BST_CELL_OUT = 25'h17e43ef; // Cells with an output driver
   localparam logic [24:0] BST_CELL_IN = 25'h0e3bcf2; // Cells with an input buffer
   // Data register path selection
   localparam logic [1:0] BST_PATH_BYPASS = 2'h0;
   localparam logic [1:0] BST_PATH_BOUND = 2'h1;
   localparam logic [1:0] BST_PATH_SELECT = 2'h2;
   // Controller timing and register map
   localparam int BST_TCK_HALF = 8;
   localparam int BST_SYNC_LAT = 6;
   localparam int BST_TLR_STEPS = 5;
   localparam logic [11:0] BST_OFF_CTRL = 12'h000;
   localparam logic [11:0] BST_OFF_TX = 12'h004;
   localparam logic [11:0] BST_OFF_RX = 12'h008;
   localparam logic [11:0] BST_OFF_STAT = 12'h00c;
   localparam int BST_CTRL_GO = 0;
   localparam int BST_CTRL_IR = 1;
   localparam int BST_CTRL_TLR = 2;
   localparam int BST_CTRL_TRST = 3;
   localparam int BST_CTRL_LEN = 8;
   localparam int BST_LEN_W = 5;
   localparam int BST_STAT_BUSY = 0;
   localparam int BST_STAT_ERR = 1;

   // TAP controller states, Gray steps along the scan paths
   typedef enum logic [3:0] {
      BST_TLR = 4'h0, BST_RTI = 4'h1, BST_SEL_DR = 4'h3, BST_CAP_DR = 4'h2,
      BST_SH_DR = 4'h6, BST_EX1_DR = 4'h7, BST_PAU_DR = 4'h5, BST_EX2_DR = 4'h4,
      BST_UPD_DR = 4'hc, BST_SEL_IR = 4'hd, BST_CAP_IR = 4'hf, BST_SH_IR = 4'he,
      BST_EX1_IR = 4'ha, BST_PAU_IR = 4'hb, BST_EX2_IR = 4'h9, BST_UPD_IR = 4'h8
   } bst_tap_t;

   // Controller sequencer states
   typedef enum logic [3:0] {
      BSTH_IDLE = 4'h0, BSTH_SEL_DR = 4'h1, BSTH_SEL_IR = 4'h3, BSTH_TO_CAP = 4'h2,
      BSTH_TO_SHIFT = 4'h6, BSTH_SHIFT = 4'h7, BSTH_UPD = 4'h5, BSTH_DONE = 4'h4,
      BSTH_TLR = 4'hc
   } bst_host_t;

   // True for the five public instruction codes
   function automatic logic bst_is_public(input logic [3:0] code);
      return (code == BST_OP_EXTEST) || (code == BST_OP_SELECT) ||
             (code == BST_OP_SAMPLE) || (code == BST_OP_INTEST) ||
             (code == BST_OP_BYPASS);
   endfunction
endpackage

// File: hw/bst_tap_dev.sv
// Purpose: Boundary-scan TAP with instruction, bypass, select and boundary registers
// Assumes: tck, tms, tdi, trst_n arrive unsynchronised; cell ports are sys_clk logic
// Notes: Link edges are found by oversampling, so tck must stay well below sys_clk/4
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module bst_tap_dev
   import bst_pkg::*;
(
   // System
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // Scan link
   bst_tap_if.dev link,
   // Boundary cell connections
   input wire logic [BST_BSR_LEN-1:0] core_out,
   input wire logic [BST_BSR_LEN-1:0] pin_in,
   output logic [BST_BSR_LEN-1:0] pin_out,
   output logic [BST_BSR_LEN-1:0] core_in,
   // Observed state
   output logic [BST_IR_W-1:0] instr,
   output logic [BST_SEL_W-1:0] chain,
   output logic tap_reset
);

   ////////////////////////////////////////////////////////////////////////////
   // Link synchronisers and edge detection

   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic tck_d_reg;
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic trst_act;
   logic rise;
   logic fall;

   // Two stages on every link input; order is {trst_n, tdi, tms, tck}
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end else if (ce) begin
         sync1_reg <= {link.trst_n, link.tdi, link.tms, link.tck};
         sync2_reg <= sync1_reg;
      end
   end

   // Delayed copy of the clean tck for edge finding
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tck_d_reg <= 1'b0;
      end else if (ce) begin
         tck_d_reg <= tck_s;
      end
   end

   // Edges; tms and tdi travel with tck so they match at the rise
   assign tck_s = sync2_reg[0];
   assign tms_s = sync2_reg[1];
   assign tdi_s = sync2_reg[2];
   assign trst_act = ~sync2_reg[3];
   assign rise = ce & tck_s & ~tck_d_reg;
   assign fall = ce & ~tck_s & tck_d_reg;

   ////////////////////////////////////////////////////////////////////////////
   // TAP controller

   bst_tap_t state_reg;
   bst_tap_t state_next;

   // Standard sixteen-state graph
   function automatic bst_tap_t tap_next(input bst_tap_t s, input logic m);
      case (s)
         BST_TLR: tap_next = m ? BST_TLR : BST_RTI;
         BST_RTI: tap_next = m ? BST_SEL_DR : BST_RTI;
         BST_SEL_DR: tap_next = m ? BST_SEL_IR : BST_CAP_DR;
         BST_CAP_DR: tap_next = m ? BST_EX1_DR : BST_SH_DR;
         BST_SH_DR: tap_next = m ? BST_EX1_DR : BST_SH_DR;
         BST_EX1_DR: tap_next = m ? BST_UPD_DR : BST_PAU_DR;
         BST_PAU_DR: tap_next = m ? BST_EX2_DR : BST_PAU_DR;
         BST_EX2_DR: tap_next = m ? BST_UPD_DR : BST_SH_DR;
         BST_UPD_DR: tap_next = m ? BST_SEL_DR : BST_RTI;
         BST_SEL_IR: tap_next = m ? BST_TLR : BST_CAP_IR;
         BST_CAP_IR: tap_next = m ? BST_EX1_IR : BST_SH_IR;
         BST_SH_IR: tap_next = m ? BST_EX1_IR : BST_SH_IR;
         BST_EX1_IR: tap_next = m ? BST_UPD_IR : BST_PAU_IR;
         BST_PAU_IR: tap_next = m ? BST_EX2_IR : BST_PAU_IR;
         BST_EX2_IR: tap_next = m ? BST_UPD_IR : BST_SH_IR;
         BST_UPD_IR: tap_next = m ? BST_SEL_DR : BST_RTI;
         default: tap_next = BST_TLR;
      endcase
   endfunction

   assign state_next = tap_next(state_reg, tms_s);

   // TRST acts without any tck edge; only sys_clk is needed
   always_ff @(posedge sys_clk) begin
      if (rst || trst_act) begin
         state_reg <= BST_TLR;
      end else if (rise) begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Instruction register and decode

   logic [BST_IR_W-1:0] ir_sh_reg;
   logic [BST_IR_W-1:0] ir_cur_reg;
   logic mode_ext;
   logic mode_int;
   logic mode_smp;
   logic mode_sel;
   logic [1:0] path;
   logic [BST_SEL_W-1:0] chain_reg;

   // Four bits, no parity; capture 0001, shift LSB first
   always_ff @(posedge sys_clk) begin
      if (rst || trst_act) begin
         ir_sh_reg <= BST_IR_CAPTURE;
         ir_cur_reg <= BST_OP_IDCODE;
      end else if (rise) begin
         case (state_reg)
            BST_TLR: ir_cur_reg <= BST_OP_IDCODE;
            BST_CAP_IR: ir_sh_reg <= BST_IR_CAPTURE;
            BST_SH_IR: ir_sh_reg <= {tdi_s, ir_sh_reg[BST_IR_W-1:1]};
            BST_UPD_IR: ir_cur_reg <= ir_sh_reg;
            default: ;
         endcase
      end
   end

   // Public codes; anything else, the identification code too, takes bypass
   assign mode_ext = (ir_cur_reg == BST_OP_EXTEST);
   assign mode_int = (ir_cur_reg == BST_OP_INTEST);
   assign mode_smp = (ir_cur_reg == BST_OP_SAMPLE);
   assign mode_sel = (ir_cur_reg == BST_OP_SELECT);

   // Reserved chain numbers see a one-bit path rather than nothing
   assign path = mode_sel ? BST_PATH_SELECT :
                 ((mode_ext || mode_int || mode_smp) && chain_reg == BST_CHAIN_BOUNDARY) ?
                 BST_PATH_BOUND : BST_PATH_BYPASS;

   ////////////////////////////////////////////////////////////////////////////
   // Bypass and scan path select registers

   logic byp_reg;
   logic [BST_SEL_W-1:0] sel_sh_reg;

   // One cell, zero at capture, no parallel output, no update action
   always_ff @(posedge sys_clk) begin
      if (rst || trst_act) begin
         byp_reg <= 1'b0;
      end else if (rise && path == BST_PATH_BYPASS) begin
         if (state_reg == BST_CAP_DR) begin
            byp_reg <= 1'b0;
         end else if (state_reg == BST_SH_DR) begin
            byp_reg <= tdi_s;
         end
      end
   end

   // Select register; chain three after any TAP reset
   always_ff @(posedge sys_clk) begin
      if (rst || trst_act) begin
         sel_sh_reg <= BST_SEL_CAPTURE;
         chain_reg <= BST_CHAIN_BOUNDARY;
      end else if (rise) begin
         if (state_reg == BST_TLR) begin
            chain_reg <= BST_CHAIN_BOUNDARY;
         end else if (path == BST_PATH_SELECT) begin
            case (state_reg)
               BST_CAP_DR: sel_sh_reg <= BST_SEL_CAPTURE;
               BST_SH_DR: sel_sh_reg <= {tdi_s, sel_sh_reg[BST_SEL_W-1:1]};
               BST_UPD_DR: chain_reg <= sel_sh_reg;
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Boundary register

   logic [BST_BSR_LEN-1:0] bsr_reg;
   logic [BST_BSR_LEN-1:0] cap_vec;

   // Capture source per mode; output-only cells keep their own value in extest
   always_comb begin
      if (mode_ext) begin
         cap_vec = (BST_CELL_IN & pin_in) | (~BST_CELL_IN & bsr_reg);
      end else if (mode_int) begin
         cap_vec = (BST_CELL_OUT & core_out) | (~BST_CELL_OUT & pin_in);
      end else begin
         cap_vec = (BST_CELL_IN & pin_in) | (~BST_CELL_IN & core_out);
      end
   end

   // Entry at chain_first_pin, exit at chain_last_pin
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bsr_reg <= '0;
      end else if (rise && path == BST_PATH_BOUND) begin
         if (state_reg == BST_CAP_DR) begin
            bsr_reg <= cap_vec;
         end else if (state_reg == BST_SH_DR) begin
            bsr_reg <= {bsr_reg[BST_BSR_LEN-2:0], tdi_s};
         end
      end
   end

   // Cells drive straight from the shift stages; no update latch in between
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pin_out <= '0;
         core_in <= '0;
      end else if (ce) begin
         pin_out <= (mode_ext && path == BST_PATH_BOUND) ?
                    (BST_CELL_OUT & bsr_reg) | (~BST_CELL_OUT & core_out) :
                    core_out;
         core_in <= (mode_int && path == BST_PATH_BOUND) ?
                    (BST_CELL_IN & bsr_reg) | (~BST_CELL_IN & pin_in) :
                    pin_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial output

   logic tdo_reg;
   logic dr_bit;

   // Last stage of whichever data path is live
   always_comb begin
      case (path)
         BST_PATH_BOUND: dr_bit = bsr_reg[BST_BSR_LEN-1];
         BST_PATH_SELECT: dr_bit = sel_sh_reg[0];
         default: dr_bit = byp_reg;
      endcase
   end

   // Changes only after a falling tck edge or when TRST clears it, so the rise sees a stable bit
   always_ff @(posedge sys_clk) begin
      if (rst || trst_act) begin
         tdo_reg <= 1'b0;
      end else if (fall) begin
         if (state_reg == BST_SH_IR) begin
            tdo_reg <= ir_sh_reg[0];
         end else if (state_reg == BST_SH_DR) begin
            tdo_reg <= dr_bit;
         end
      end
   end

   assign link.tdo = tdo_reg;
   assign instr = ir_cur_reg;
   assign chain = chain_reg;
   assign tap_reset = (state_reg == BST_TLR);

endmodule
`default_nettype wire

// File: hw/bst_tap_host.sv
// Purpose: Scan controller that runs IR and DR shifts on orders from APB
// Assumes: Software writes TX data before issuing a shift order
// Notes: tck is made here by dividing sys_clk and is driven out free-running
`timescale 1ns/10ps
`default_nettype none
module bst_tap_host
   import bst_pkg::*;
#(
   parameter int TCK_HALF = BST_TCK_HALF
) (
   // System
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Scan link
   bst_tap_if.host link
);

   // The TAP needs several sys_clk cycles to see each tck level
   if (TCK_HALF < BST_SYNC_LAT || TCK_HALF > 255) begin : g_chk
      $error("TCK_HALF out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0] div_reg;
   logic tck_reg, tms_reg, tdi_reg, trst_hold_reg;
   logic ir_reg, tlr_reg, pend_reg, err_reg;
   logic [BST_LEN_W-1:0] len_reg, cnt_reg;
   logic [31:0] tx_reg, rx_reg, prdata_reg;
   logic [3:0] last_ir_reg;
   logic tdo_s1_reg, tdo_s2_reg;
   bst_host_t st_reg;
   logic wr, busy, wrap, rise, fall, go, refuse;

   assign wr = psel & penable & pwrite & ce;
   assign busy = pend_reg | (st_reg != BSTH_IDLE);

   // Reserved instructions and chain numbers are refused at the order
   assign go = wr && paddr == BST_OFF_CTRL && pwdata[BST_CTRL_GO] && !busy;
   assign refuse = go && pwdata[BST_CTRL_LEN +: BST_LEN_W] == 5'(BST_IR_W - 1) &&
                   (pwdata[BST_CTRL_IR] ? !bst_is_public(tx_reg[3:0]) :
                   (last_ir_reg == BST_OP_SELECT && tx_reg[3:0] != BST_CHAIN_BOUNDARY));

   // Order fields are frozen while a shift runs
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ir_reg <= 1'b0;
         tlr_reg <= 1'b0;
         len_reg <= '0;
         tx_reg <= '0;
         trst_hold_reg <= 1'b1;
      end else if (wr && !busy) begin
         if (paddr == BST_OFF_CTRL) begin
            ir_reg <= pwdata[BST_CTRL_IR];
            tlr_reg <= pwdata[BST_CTRL_TLR];
            len_reg <= pwdata[BST_CTRL_LEN +: BST_LEN_W];
            trst_hold_reg <= pwdata[BST_CTRL_TRST];
         end else if (paddr == BST_OFF_TX) begin
            tx_reg <= pwdata;
         end
      end
   end

   // Pending order and sticky refusal flag; a new refusal beats the clear
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pend_reg <= 1'b0;
         err_reg <= 1'b0;
      end else if (ce) begin
         if (go && !refuse && !pwdata[BST_CTRL_TRST]) begin
            pend_reg <= 1'b1;
         end else if (rise && st_reg == BSTH_IDLE) begin
            pend_reg <= 1'b0;
         end
         err_reg <= refuse | (err_reg & ~(wr && paddr == BST_OFF_STAT &&
                                          pwdata[BST_STAT_ERR]));
      end
   end

   // Read data set up in the first APB cycle, so there are no wait states
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prdata_reg <= '0;
      end else if (ce && psel && !penable) begin
         case (paddr)
            BST_OFF_CTRL: prdata_reg <= {19'h0, len_reg, 4'h0, trst_hold_reg, tlr_reg,
                                         ir_reg, 1'b0};
            BST_OFF_TX: prdata_reg <= tx_reg;
            BST_OFF_RX: prdata_reg <= rx_reg;
            BST_OFF_STAT: prdata_reg <= {30'h0, err_reg, busy};
            default: prdata_reg <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock divider and link synchroniser

   assign wrap = ce && div_reg == 8'(TCK_HALF - 1);
   assign rise = wrap & ~tck_reg;
   assign fall = wrap & tck_reg;

   // Free-running tck; tms and tdi move on its fall, tdo is taken on its rise
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_reg <= '0;
         tck_reg <= 1'b0;
      end else if (ce) begin
         div_reg <= wrap ? 8'h00 : div_reg + 8'h01;
         if (wrap) begin
            tck_reg <= ~tck_reg;
         end
      end
   end

   // Two stages for the returning tdo
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tdo_s1_reg <= 1'b0;
         tdo_s2_reg <= 1'b0;
      end else if (ce) begin
         tdo_s1_reg <= link.tdo;
         tdo_s2_reg <= tdo_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   // Drive tms and tdi for the coming rise
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tms_reg <= 1'b0;
         tdi_reg <= 1'b0;
      end else if (fall) begin
         tms_reg <= (st_reg == BSTH_TLR) || (st_reg == BSTH_SEL_DR) ||
                    (st_reg == BSTH_SEL_IR) || (st_reg == BSTH_UPD) ||
                    (st_reg == BSTH_SHIFT && cnt_reg == len_reg);
         tdi_reg <= (st_reg == BSTH_SHIFT) ? tx_reg[cnt_reg] : 1'b0;
      end
   end

   // Advance once per rise; tdo bit taken in the same rise
   always_ff @(posedge sys_clk) begin
      if (rst || trst_hold_reg) begin
         st_reg <= BSTH_IDLE;
         cnt_reg <= '0;
         rx_reg <= '0;
         last_ir_reg <= BST_OP_IDCODE;
      end else if (rise) begin
         case (st_reg)
            BSTH_IDLE: begin
               if (pend_reg) begin
                  st_reg <= tlr_reg ? BSTH_TLR : BSTH_SEL_DR;
               end
               cnt_reg <= '0;
            end
            BSTH_TLR: begin
               cnt_reg <= cnt_reg + 5'h01;
               if (cnt_reg == 5'(BST_TLR_STEPS - 1)) begin
                  st_reg <= BSTH_DONE;
                  last_ir_reg <= BST_OP_IDCODE;
               end
            end
            BSTH_SEL_DR: st_reg <= ir_reg ? BSTH_SEL_IR : BSTH_TO_CAP;
            BSTH_SEL_IR: st_reg <= BSTH_TO_CAP;
            BSTH_TO_CAP: st_reg <= BSTH_TO_SHIFT;
            BSTH_TO_SHIFT: begin
               st_reg <= BSTH_SHIFT;
               cnt_reg <= '0;
            end
            BSTH_SHIFT: begin
               rx_reg[cnt_reg] <= tdo_s2_reg;
               cnt_reg <= cnt_reg + 5'h01;
               if (cnt_reg == len_reg) begin
                  st_reg <= BSTH_UPD;
               end
            end
            BSTH_UPD: begin
               st_reg <= BSTH_DONE;
               if (ir_reg && !tlr_reg && len_reg == 5'(BST_IR_W - 1)) begin
                  last_ir_reg <= tx_reg[3:0];
               end
            end
            BSTH_DONE: st_reg <= BSTH_IDLE;
            default: st_reg <= BSTH_IDLE;
         endcase
      end
   end

   assign link.tck = tck_reg;
   assign link.tms = tms_reg;
   assign link.tdi = tdi_reg;
   assign link.trst_n = ~trst_hold_reg;
   assign prdata = prdata_reg;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

endmodule
`default_nettype wire

// File: hw/bst_tap_if.sv
// Purpose: Boundary-scan link between test controller and TAP
// Assumes: Plain push-pull wires, no tristate on the link
// Notes: The controller makes tck; the TAP only samples it
`timescale 1ns/10ps
`default_nettype none
interface bst_tap_if;
   logic tck;
   logic tms;
   logic tdi;
   logic trst_n;
   logic tdo;
   modport dev (input tck, input tms, input tdi, input trst_n, output tdo);
   modport host (output tck, output tms, output tdi, output trst_n, input tdo);
endinterface
`default_nettype wire
